// file: hdl/clock_select_pkg.sv
// Constants for the system clock source selector
package clock_select_pkg;
	// Oscillator mode codes held in the nonvolatile mode field
	localparam logic [2:0] MODE_LOW_POWER_CRYSTAL  = 3'h0;
	localparam logic [2:0] MODE_CRYSTAL_RESONATOR  = 3'h1;
	localparam logic [2:0] MODE_HIGH_SPEED_CRYSTAL = 3'h2;
	localparam logic [2:0] MODE_HS_PLL             = 3'h3;
	localparam logic [2:0] MODE_RC_CLKOUT          = 3'h4;
	localparam logic [2:0] MODE_RC_GPIO            = 3'h5;
	localparam logic [2:0] MODE_EXT_CLKOUT         = 3'h6;
	localparam logic [2:0] MODE_EXT_GPIO           = 3'h7;

	// Register byte offsets
	localparam logic [7:0] OFFSET_OSC_CONTROL = 8'h00;
	localparam logic [7:0] OFFSET_CLOCK_STATUS = 8'h04;
	// Field positions
	localparam int SEL_BIT        = 0;
	localparam int STAT_SECONDARY = 0;
	localparam int STAT_RUNNING   = 1;
	localparam int STAT_MODE_LO   = 2;
	localparam int STAT_SWITCH_N  = 5;
	localparam int STAT_ALLOWED   = 6;
	// Values after reset, and the last quarter
	localparam logic SEL_RESET     = 1'b0;
	localparam logic [1:0] QUARTER_FIRST = 2'h0;
	localparam logic [1:0] QUARTER_LAST  = 2'h3;

	// Counts and times
	localparam logic [19:0] OST_COUNT  = 20'h00400;
	localparam logic [19:0] SYNC_COUNT = 20'h00008;
	localparam int PLL_LOCK_US   = 2000;
	localparam int CLOCK_MHZ     = 250;
	localparam int PLL_LOCK_CYCLES = PLL_LOCK_US * CLOCK_MHZ;
	localparam logic [1:0] PLL_MID_TICKS = 2'h3;
endpackage : clock_select_pkg

// file: hdl/system_clock_source_select.sv
// System clock source selection, start-up waits and glitch-free switching
//
// Register access over Wishbone and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none

// Contract
// RULE1 - Eight primary modes from fixed three-bit field
// RULE2 - RC mode drives oscillator divided by four
// RULE3 - RC gpio mode: pin becomes port A bit6
// RULE4 - External clock mode drives divide-by-four out
// RULE5 - External gpio mode: pin is general I/O
// RULE6 - External modes switch feedback element off
// RULE7 - External modes apply no start-up wait
// RULE8 - PLL mode multiplies crystal frequency by four
// RULE9 - PLL only in PLL mode, else direct
// RULE10 - Execution held until PLL lock time expires
// RULE11 - Switching only when enable bit programmed zero
// RULE12 - Select zero primary, one secondary oscillator
// RULE13 - Every reset clears the select bit
// RULE14 - Disabled switching forces select to zero
// RULE15 - Control bits seven to one read zero
// RULE16 - Eight target rising edges before using it
// RULE17 - Freeze at first quarter, resume after eight
// RULE18 - Crystal return adds start-up wait
// RULE19 - PLL return adds start-up plus lock wait
// RULE20 - RC/external return waits eight primary cycles
// RULE21 - Start-up wait is 1024 input cycles
// RULE22 - Gate clock cleanly, restart at first quarter
module system_clock_source_select
	import clock_select_pkg::*;
#(
	parameter int PLL_LOCK = PLL_LOCK_CYCLES
)(
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic [2:0]  oscModeStrap,
	input  wire logic        clockSwitchEnableStrap_n,
	input  wire logic        secondaryOscEnable,
	input  wire logic        oscInPin,
	input  wire logic        secondaryOscPin,
	input  wire logic        oscOutPinIn,
	output logic             oscOutPinOut,
	output logic             oscOutPinOe_n,
	input  wire logic        portaBit6Out,
	input  wire logic        portaBit6Drive,
	output logic             portaBit6In,
	output logic             feedbackEnable,
	output logic             pllEnable,
	output logic             cpuRun,
	output logic             sysClkEn,
	output logic [1:0]       quarterPhase,
	output logic             firstQuarterPhase,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o
);
	typedef enum logic [2:0] {ST_START, ST_OST, ST_PLL, ST_RUN, ST_SYNC} state_t;

	state_t      state;
	logic [2:0]  modeSel;
	logic        switchEnable_n;
	logic        sysClockSelect;
	logic        onSecondary;
	logic        target;
	logic        inSwitch;
	logic [19:0] waitCnt;
	logic [1:0]  primSync;
	logic [1:0]  secSync;
	logic [1:0]  padSync;
	logic        primPrev;
	logic        secPrev;
	logic        primEdge;
	logic        secEdge;
	logic [15:0] periodCnt;
	logic [15:0] period;
	logic [15:0] subCnt;
	logic [1:0]  midTicks;
	logic        pllTick;
	logic        primTick;
	logic        activeTick;
	logic        targetEdge;
	logic [1:0]  primDiv;
	logic        crystalMode;
	logic        extMode;
	logic        gpioMode;
	logic        switchAllowed;
	logic        wbReq;

	// Nonvolatile fields taken while reset is high
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			modeSel        <= oscModeStrap;             // [RULE1]
			switchEnable_n <= clockSwitchEnableStrap_n;
		end
	end

	assign crystalMode   = (modeSel == MODE_LOW_POWER_CRYSTAL) ||
		(modeSel == MODE_CRYSTAL_RESONATOR) || (modeSel == MODE_HIGH_SPEED_CRYSTAL) ||
		(modeSel == MODE_HS_PLL);
	assign extMode       = (modeSel == MODE_EXT_CLKOUT) || (modeSel == MODE_EXT_GPIO);
	assign gpioMode      = (modeSel == MODE_RC_GPIO) || (modeSel == MODE_EXT_GPIO);
	assign switchAllowed = !switchEnable_n && secondaryOscEnable; // [RULE11]

	// Pin synchronisers
	always_ff @(posedge mclk)
	begin
		primSync <= {primSync[0], oscInPin};
		secSync  <= {secSync[0], secondaryOscPin};
		padSync  <= {padSync[0], oscOutPinIn};
		primPrev <= primSync[1];
		secPrev  <= secSync[1];
	end

	assign primEdge = primSync[1] && !primPrev;
	assign secEdge  = secSync[1] && !secPrev;

	// Times-four clock: one tick per edge plus three spread over the period
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			periodCnt <= 16'h0000;
			period    <= 16'h0000;
			subCnt    <= 16'h0000;
			midTicks  <= 2'h0;
		end
		else if (primEdge)
		begin
			periodCnt <= 16'h0000;
			period    <= periodCnt + 16'h0001;
			subCnt    <= 16'h0000;
			midTicks  <= 2'h0;
		end
		else
		begin
			periodCnt <= periodCnt + 16'h0001;
			if (pllTick)
			begin
				subCnt   <= 16'h0000;
				midTicks <= midTicks + 2'h1;
			end
			else
			begin
				subCnt <= subCnt + 16'h0001;
			end
		end
	end

	assign pllTick = primEdge || (midTicks != PLL_MID_TICKS && period[15:2] != 14'h0000 &&
		subCnt + 16'h0001 == {2'h0, period[15:2]}); // [RULE8]
	assign primTick   = pllEnable ? pllTick : primEdge; // [RULE9]
	assign activeTick = onSecondary ? secEdge : primTick;
	assign targetEdge = target ? secEdge : primEdge;

	// Mode-fixed pin controls
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			pllEnable      <= 1'b0;
			feedbackEnable <= 1'b0;
		end
		else
		begin
			pllEnable      <= (modeSel == MODE_HS_PLL);  // [RULE9]
			feedbackEnable <= !extMode;                  // [RULE6]
		end
	end

	// Divide-by-four of the primary oscillator
	always_ff @(posedge mclk)
	begin
		if (srst)
			primDiv <= 2'h0;
		else if (primEdge)
			primDiv <= primDiv + 2'h1;
	end

	// Second oscillator pin
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			oscOutPinOut  <= 1'b0;
			oscOutPinOe_n <= 1'b1;
			portaBit6In   <= 1'b0;
		end
		else if (gpioMode)
		begin
			oscOutPinOut  <= portaBit6Out;               // [RULE3] [RULE5]
			oscOutPinOe_n <= !portaBit6Drive;
			portaBit6In   <= padSync[1];
		end
		else
		begin
			oscOutPinOut  <= primDiv[1];                 // [RULE2] [RULE4]
			oscOutPinOe_n <= crystalMode;
			portaBit6In   <= 1'b0;
		end
	end

	// Select bit
	always_ff @(posedge mclk)
	begin
		if (srst)
			sysClockSelect <= SEL_RESET;                  // [RULE13]
		else if (!switchAllowed)
			sysClockSelect <= 1'b0;                       // [RULE14]
		else if (wbReq && wb_ack_o && wb_we_i && wb_sel_i[0] &&
			wb_adr_i == OFFSET_OSC_CONTROL)
			sysClockSelect <= wb_dat_i[SEL_BIT];          // [RULE12]
	end

	// Start-up and switching sequencer
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			state       <= ST_START;
			onSecondary <= 1'b0;
			target      <= 1'b0;
			inSwitch    <= 1'b0;
			waitCnt     <= 20'h00000;
		end
		else
		begin
			unique case (state)
				ST_START:
				begin
					waitCnt  <= 20'h00000;
					inSwitch <= 1'b0;
					state    <= crystalMode ? ST_OST : ST_RUN; // [RULE7]
				end
				ST_OST:
				begin
					if (primEdge)
					begin
						if (waitCnt == OST_COUNT - 20'h00001)  // [RULE21] [RULE18]
						begin
							waitCnt <= 20'h00000;
							if (pllEnable)
								state <= ST_PLL;
							else
								state <= inSwitch ? ST_SYNC : ST_RUN;
						end
						else
							waitCnt <= waitCnt + 20'h00001;
					end
				end
				ST_PLL:
				begin
					if (waitCnt == 20'(PLL_LOCK - 1))          // [RULE10] [RULE19]
					begin
						waitCnt <= 20'h00000;
						state   <= inSwitch ? ST_SYNC : ST_RUN;
					end
					else
						waitCnt <= waitCnt + 20'h00001;
				end
				ST_RUN:
				begin
					// Freeze as the phase wraps to the first quarter
					if (sysClockSelect != onSecondary && activeTick &&
						quarterPhase == QUARTER_LAST)         // [RULE17] [RULE22]
					begin
						target   <= sysClockSelect;
						inSwitch <= 1'b1;
						waitCnt  <= 20'h00000;
						state    <= (!sysClockSelect && crystalMode) ? ST_OST : ST_SYNC;
					end
				end
				ST_SYNC:
				begin
					if (targetEdge)
					begin
						if (waitCnt == SYNC_COUNT - 20'h00001) // [RULE16] [RULE20]
						begin
							onSecondary <= target;
							inSwitch    <= 1'b0;
							waitCnt     <= 20'h00000;
							state       <= ST_RUN;
						end
						else
							waitCnt <= waitCnt + 20'h00001;
					end
				end
			endcase
		end
	end

	assign cpuRun   = (state == ST_RUN);
	assign sysClkEn = cpuRun && activeTick;

	// Instruction quarter phase
	always_ff @(posedge mclk)
	begin
		if (srst)
			quarterPhase <= QUARTER_FIRST;
		else if (state == ST_SYNC)
			quarterPhase <= QUARTER_FIRST;                // [RULE22]
		else if (sysClkEn)
			quarterPhase <= quarterPhase + 2'h1;
	end

	assign firstQuarterPhase = cpuRun && quarterPhase == QUARTER_FIRST;

	// Wishbone slave: ack one cycle after the request
	assign wbReq = wb_cyc_i && wb_stb_i;

	always_ff @(posedge mclk)
	begin
		if (srst)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wbReq && !wb_ack_o;
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
			wb_dat_o <= 32'h00000000;
		else if (wbReq && !wb_ack_o)
		begin
			wb_dat_o <= 32'h00000000;                      // [RULE15]
			if (wb_adr_i == OFFSET_OSC_CONTROL)
				wb_dat_o[SEL_BIT] <= sysClockSelect;
			else if (wb_adr_i == OFFSET_CLOCK_STATUS)
			begin
				wb_dat_o[STAT_SECONDARY] <= onSecondary;
				wb_dat_o[STAT_RUNNING]   <= cpuRun;
				wb_dat_o[STAT_MODE_LO +: 3] <= modeSel;
				wb_dat_o[STAT_SWITCH_N]  <= switchEnable_n;
				wb_dat_o[STAT_ALLOWED]   <= switchAllowed;
			end
		end
	end

	// Checks
	sequence syncLastEdge;
		state == ST_SYNC && targetEdge && waitCnt == SYNC_COUNT - 20'h00001;
	endsequence

	sequence restartFirst;
		cpuRun && quarterPhase == QUARTER_FIRST;
	endsequence

	a_sel_forced: assert property (@(posedge mclk) disable iff (srst) // [RULE14]
		!switchAllowed |=> !sysClockSelect)
		else $error("select bit not forced clear");

	a_reset_clears: assert property (@(posedge mclk) // [RULE13]
		srst |=> !sysClockSelect)
		else $error("select bit survives reset");

	a_upper_zero: assert property (@(posedge mclk) disable iff (srst) // [RULE15]
		wb_ack_o |-> wb_dat_o[31:7] == 25'h0)
		else $error("unimplemented bits read nonzero");

	a_pll_only: assert property (@(posedge mclk) disable iff (srst) // [RULE9]
		pllEnable |-> modeSel == MODE_HS_PLL)
		else $error("pll enabled outside pll mode");

	a_ost_len: assert property (@(posedge mclk) disable iff (srst) // [RULE21]
		$fell(state == ST_OST) |-> $past(waitCnt) == OST_COUNT - 20'h00001)
		else $error("start-up wait not 1024 input cycles");

	a_ext_nowait: assert property (@(posedge mclk) disable iff (srst) // [RULE7]
		extMode |-> state != ST_OST && state != ST_PLL)
		else $error("start-up wait in external clock mode");

	a_sync_resume: assert property (@(posedge mclk) disable iff (srst) // [RULE17]
		syncLastEdge |=> restartFirst ##0 onSecondary == $past(target))
		else $error("no restart after eight sync edges");

	a_freeze_q1: assert property (@(posedge mclk) disable iff (srst) // [RULE22]
		$fell(cpuRun) && $past(state) == ST_RUN |-> ##1 quarterPhase == QUARTER_FIRST)
		else $error("clock not frozen at first quarter");

	a_pll_lock: assert property (@(posedge mclk) disable iff (srst) // [RULE10]
		$fell(state == ST_PLL) |-> $past(waitCnt) == 20'(PLL_LOCK - 1))
		else $error("pll lock wait wrong length");

	a_clkout_pin: assert property (@(posedge mclk) disable iff (srst) // [RULE2]
		(modeSel == MODE_RC_CLKOUT || modeSel == MODE_EXT_CLKOUT) ##1 !srst
		|-> !oscOutPinOe_n)
		else $error("clock out not driven");
endmodule : system_clock_source_select

`default_nettype wire

// file: test/osc_source_model.sv
// Free-running primary and secondary oscillator sources with the pad pull-up
`timescale 1ns/100ps
`default_nettype none
module osc_source_model #(
	parameter real PRIM_HALF_NS = 16.0,
	parameter real SEC_HALF_NS  = 40.0
)(
	input  wire logic oeN,
	input  wire logic padOut,
	output logic      primPin,
	output logic      secPin,
	output wire logic padLevel
);
	// Phases offset from the system clock
	initial
	begin
		primPin = 1'b0;
		#1.3;
		forever #(PRIM_HALF_NS) primPin = ~primPin;
	end
	initial
	begin
		secPin = 1'b0;
		#0.7;
		forever #(SEC_HALF_NS) secPin = ~secPin;
	end
	// Released pad is pulled up
	assign padLevel = oeN ? 1'b1 : padOut;
endmodule : osc_source_model
`default_nettype wire

// file: test/system_clock_source_select_tb_top.sv
// Register-level bench for the system clock source selector
`timescale 1ns/100ps
`default_nettype none
module system_clock_source_select_tb_top;
	import clock_select_pkg::*;
	logic        mclk, srst, strapN, t1En, bitOut, bitDrive, cyc, stb, we, ack;
	logic        oeN, padOut, primPin, secPin, fbEn, pllEn, run, tick, outPrev;
	logic        bit6In, firstQ;
	logic [1:0]  phase;
	logic [2:0]  modeStrap;
	logic [7:0]  adr;
	logic [31:0] wdat, rdat, q;
	wire logic   pad;
	int          n_fail, samples_checked, cycles, ticks, outRises, lowCycles, q1Ticks;

	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	system_clock_source_select #(.PLL_LOCK(20)) dut (.mclk(mclk), .srst(srst),
		.oscModeStrap(modeStrap), .clockSwitchEnableStrap_n(strapN),
		.secondaryOscEnable(t1En), .oscInPin(primPin), .secondaryOscPin(secPin),
		.oscOutPinIn(pad), .oscOutPinOut(padOut), .oscOutPinOe_n(oeN),
		.portaBit6Out(bitOut), .portaBit6Drive(bitDrive), .portaBit6In(bit6In),
		.feedbackEnable(fbEn), .pllEnable(pllEn), .cpuRun(run), .sysClkEn(tick),
		.quarterPhase(phase), .firstQuarterPhase(firstQ), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack));
	osc_source_model model (.oeN(oeN), .padOut(padOut), .primPin(primPin),
		.secPin(secPin), .padLevel(pad));

	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish

	always @(posedge mclk)
	begin
		cycles++;
		ticks += (tick === 1'b1);
		q1Ticks += (tick === 1'b1 && firstQ === 1'b1 && phase === QUARTER_FIRST);
		outRises += (oeN === 1'b0 && padOut === 1'b1 && outPrev !== 1'b1);
		outPrev <= padOut;
		lowCycles += (run !== 1'b1);
		if (cycles > 80000)
		begin
			n_fail++;
			tally_and_finish();
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		check(n < 50, 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge mclk);
	endtask : wb

	task doReset(input logic [2:0] m, input logic sn);
		srst <= 1'b1;
		modeStrap <= m;
		strapN <= sn;
		t1En <= 1'b0;
		repeat (20) @(posedge mclk);
		srst <= 1'b0;
		lowCycles = 0;
		repeat (4) @(posedge mclk);
	endtask : doReset

	task waitSel(input logic v);
		int n;
		n = 0;
		do
		begin
			wb(1'b0, OFFSET_CLOCK_STATUS, 32'h0);
			n++;
		end
		while (q[STAT_SECONDARY] !== v && n < 4000);
		check(q[STAT_SECONDARY], v);
	endtask : waitSel

	task measure(input int expTicks, input int expRises);
		ticks = 0;
		outRises = 0;
		q1Ticks = 0;
		repeat (800) @(posedge mclk);
		check(ticks >= expTicks - 4 && ticks <= expTicks + 4, 1'b1);
		check(outRises >= expRises - 2 && outRises <= expRises + 2, 1'b1);
		check(q1Ticks >= expTicks / 4 - 2 && q1Ticks <= expTicks / 4 + 2, 1'b1);
	endtask : measure

	initial
	begin
		srst = 1'b1;
		modeStrap = MODE_HS_PLL;
		{strapN, t1En, bitOut, bitDrive, cyc, stb, we, outPrev} = 8'h00;
		adr = 8'h00;
		wdat = 32'h0;
		{n_fail, samples_checked, cycles, ticks, outRises, lowCycles, q1Ticks} = '0;
		@(posedge mclk);
		doReset(MODE_HS_PLL, 1'b0);
		check({pllEn, fbEn, oeN, run}, 4'hE);
		while (run !== 1'b1 && lowCycles < 9000) @(posedge mclk);
		check(lowCycles >= 8200 && lowCycles <= 8260, 1'b1);
		measure(400, 0);
		$display("pll start-up test done");
		wb(1'b0, OFFSET_OSC_CONTROL, 32'h0);
		check(q, 32'h0);
		wb(1'b0, 8'h10, 32'h0);
		check(q, 32'h0);
		wb(1'b0, OFFSET_CLOCK_STATUS, 32'h0);
		check(q, 32'h0000000E);
		wb(1'b1, OFFSET_OSC_CONTROL, 32'hFF);
		wb(1'b0, OFFSET_OSC_CONTROL, 32'h0);
		check(q, 32'h0);
		t1En <= 1'b1;
		lowCycles = 0;
		wb(1'b1, OFFSET_OSC_CONTROL, 32'hFF);
		wb(1'b0, OFFSET_OSC_CONTROL, 32'h0);
		check(q, 32'h1);
		waitSel(1'b1);
		check(lowCycles >= 140 && lowCycles <= 200, 1'b1);
		measure(40, 0);
		wb(1'b1, OFFSET_OSC_CONTROL, 32'h0);
		lowCycles = 0;
		waitSel(1'b0);
		check(lowCycles >= 8260 && lowCycles <= 8320, 1'b1);
		$display("switching test done");
		doReset(MODE_RC_CLKOUT, 1'b1);
		t1En <= 1'b1;
		wb(1'b1, OFFSET_OSC_CONTROL, 32'h1);
		wb(1'b0, OFFSET_OSC_CONTROL, 32'h0);
		check(q, 32'h0);
		for (int m = 4; m < 8; m++)
		begin
			doReset(m[2:0], 1'b0);
			check(lowCycles <= 6, 1'b1);
			check({fbEn, pllEn, oeN}, {m < 6, 1'b0, m[0] == 1});
			measure(100, m[0] ? 0 : 25);
			bitDrive <= m[0];
			bitOut <= 1'b0;
			repeat (6) @(posedge mclk);
			check({oeN, bit6In}, 2'h0);
			bitDrive <= 1'b0;
			repeat (6) @(posedge mclk);
			check({oeN, bit6In}, {m[0], m[0]});
			t1En <= 1'b1;
			wb(1'b1, OFFSET_OSC_CONTROL, 32'h1);
			waitSel(1'b1);
			wb(1'b1, OFFSET_OSC_CONTROL, 32'h0);
			lowCycles = 0;
			waitSel(1'b0);
			check(lowCycles >= 56 && lowCycles <= 80, 1'b1);
			$display("mode %0d test done", m);
		end
		for (int m = 0; m < 3; m++)
		begin
			doReset(m[2:0], 1'b0);
			check({pllEn, fbEn, oeN, run}, 4'h6);
			while (run !== 1'b1 && lowCycles < 9000) @(posedge mclk);
			check(lowCycles >= 8180 && lowCycles <= 8200, 1'b1);
			measure(100, 0);
			$display("crystal mode %0d test done", m);
		end
		t1En <= 1'b1;
		wb(1'b1, OFFSET_OSC_CONTROL, 32'h1);
		waitSel(1'b1);
		wb(1'b1, OFFSET_OSC_CONTROL, 32'h0);
		lowCycles = 0;
		waitSel(1'b0);
		check(lowCycles >= 8240 && lowCycles <= 8275, 1'b1);
		$display("crystal return test done");
		tally_and_finish();
	end
endmodule : system_clock_source_select_tb_top
`default_nettype wire
